//--- rtl/bpc_port.sv
// Eight-pin bidirectional port with direction and latch registers, weak
// pull-up control, analog defaults on the low pins and change detection on the
// upper four pins. Registers are reached over APB; pins are synchronous inputs.
// Functional notes
// (R1) Eight bidirectional pins, each with a direction bit and output latch bit.
// (R2) Direction 1 floats the driver; direction 0 drives the latch bit.
// (R3) Latch register is addressable; reads return latch, not pin levels.
// (R4) Bit 7 of irq_control_two, active low, enables all weak pull-ups.
// (R5) Pull-up on a pin is off whenever that pin is an output.
// (R6) After reset every weak pull-up is disabled.
// (R7) Reset default: low five pins analog reading zero, upper three digital.
// (R8) Configuration input picks analog or digital reset state of low pins.
// (R9) Only upper four pins that are inputs take part in change detection.
// (R10) Each eligible pin is compared with its snapshot from the last data access.
// (R11) Mismatches are ORed and set the change flag at bit 0 of irq_control_main.
// (R12) The change interrupt is a wake source for sleep and idle modes.
// (R13) Reads and writes of pin data refresh the snapshot, except mem-to-mem destination.
// (R14) The flag is set again each cycle while a mismatch lasts.
// (R15) Software accesses pin data, waits one cycle, then clears the flag.
// (R16) Software should avoid polling pin data while change detection is used.
// (R17) Analog selection keeps latch drive but blocks the digital input buffer; code blocks pin data and pin 4 compare, EXT_IRQ, fault, capture see pad.
// (R18) With capcmp2_pin_select low, pin 3 carries the second capture/compare signal.
// (R19) Pins 0..2 feed external interrupts 0..2; pin 0 also feeds the fault input.
// (R20) With low-voltage programming enabled, pin 5 is only the programming entry input.
// (R21) During serial programming or debug, pin 6 is clock and pin 7 data.
// (R22) Writing pin data updates the latch; reading returns pins, analog reading zero.
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module bpc_port (
   input  wire logic        SYS_CLK,
   input  wire logic        ARST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   input  wire logic [3:0]  PSTRB,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        MEM_TO_MEM_MOVE,
   input  wire logic        LOW_PINS_ANALOG_DEFAULT,
   input  wire logic        CAPCMP2_PIN_SELECT,
   input  wire logic        LOW_VOLTAGE_PROG_ENABLE,
   input  wire logic [7:0]  PIN_IN,
   output logic      [7:0]  PIN_OUT,
   output logic      [7:0]  PIN_OE,
   output logic      [7:0]  PIN_PULLUP,
   output logic      [4:0]  ANALOG_SEL,
   input  wire logic        CAPCMP_UNIT_TWO_OUT,
   output logic             CAPCMP_UNIT_TWO_IN,
   output logic      [2:0]  EXT_IRQ,
   output logic             PWM_FAULT_INPUT,
   output logic             PROG_MODE_ENTRY,
   output logic             PROG_SERIAL_CLOCK,
   output logic             PROG_SERIAL_DATA_IN,
   input  wire logic        PROG_SERIAL_DATA_OUT,
   input  wire logic        PROG_SERIAL_DATA_OE,
   output logic             PORT_CHANGE_IRQ,
   output logic             WAKE_REQ
);
   logic [7:0] latch_reg, latch_next;
   logic [7:0] dir_reg, dir_next;
   logic       pullup_n_reg, pullup_n_next;
   logic       flag_reg, flag_next;
   logic [4:0] analog_reg, analog_next;
   logic [1:0] func_reg, func_next;
   logic [3:0] snap_reg, snap_next;
   logic       init_reg, init_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [7:0] pin_digital;
   logic [3:0] mismatch;
   logic       serial_act;
   logic       wr_en;
   logic       rd_en;

   function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
      hit = (addr == off);
   endfunction

   assign wr_en      = PSEL && PENABLE && PWRITE;
   // Read data is loaded in the setup cycle so it already stands at the access edge
   assign rd_en      = PSEL && !PENABLE && !PWRITE;
   assign serial_act = func_reg[bpc_pkg::BIT_SERIAL_ACT];
   assign PREADY     = 1'b1;
   assign PSLVERR    = 1'b0;
   assign PRDATA     = rdata_reg;

   // Analog pins see no digital input; unmonitored functions read the pad level
   assign pin_digital = {PIN_IN[7:5], PIN_IN[4:0] & ~analog_reg}; // R17 R22 R7

   // Mismatch only on upper pins set as inputs
   generate
      for (genvar i = 0; i < 4; i++) begin : g_cmp
         assign mismatch[i] = dir_reg[i+4] && (pin_digital[i+4] != snap_reg[i]); // R9 R10
      end
   endgenerate

   always_comb begin
      latch_next    = latch_reg;
      dir_next      = dir_reg;
      pullup_n_next = pullup_n_reg;
      flag_next     = flag_reg;
      analog_next   = analog_reg;
      func_next     = func_reg;
      snap_next     = snap_reg;
      init_next     = 1'b0;
      rdata_next    = rdata_reg;
      // Strap is caught on the first clock after reset release
      if (init_reg) begin
         analog_next = LOW_PINS_ANALOG_DEFAULT ? bpc_pkg::ANALOG_ALL : 5'h00; // R8 R7
      end
      if (wr_en && PSTRB[0]) begin
         if (hit(PADDR, bpc_pkg::OFF_PIN_DATA)) begin
            latch_next = PWDATA[7:0]; // R22
         end else if (hit(PADDR, bpc_pkg::OFF_LATCH)) begin
            latch_next = PWDATA[7:0]; // R3
         end else if (hit(PADDR, bpc_pkg::OFF_DIRECTION)) begin
            dir_next = PWDATA[7:0]; // R1
         end else if (hit(PADDR, bpc_pkg::OFF_IRQ_MAIN)) begin
            flag_next = PWDATA[bpc_pkg::BIT_CHANGE_FLAG];
         end else if (hit(PADDR, bpc_pkg::OFF_IRQ_TWO)) begin
            pullup_n_next = PWDATA[bpc_pkg::BIT_PULLUP_N]; // R4
         end else if (hit(PADDR, bpc_pkg::OFF_ANALOG_SEL)) begin
            analog_next = PWDATA[4:0];
         end else if (hit(PADDR, bpc_pkg::OFF_FUNC_CTRL)) begin
            func_next = PWDATA[1:0];
         end
      end
      // Any data access refreshes the snapshot unless it is a move destination
      if (PSEL && PENABLE && hit(PADDR, bpc_pkg::OFF_PIN_DATA) && !(PWRITE && MEM_TO_MEM_MOVE)) begin
         snap_next = pin_digital[7:4]; // R13
      end
      // Hardware set wins over a software clear in the same cycle
      if (|mismatch) begin
         flag_next = 1'b1; // R11 R14
      end
      if (rd_en) begin
         if (hit(PADDR, bpc_pkg::OFF_PIN_DATA)) begin
            rdata_next = {24'h000000, pin_digital}; // R22
         end else if (hit(PADDR, bpc_pkg::OFF_LATCH)) begin
            rdata_next = {24'h000000, latch_reg}; // R3
         end else if (hit(PADDR, bpc_pkg::OFF_DIRECTION)) begin
            rdata_next = {24'h000000, dir_reg};
         end else if (hit(PADDR, bpc_pkg::OFF_IRQ_MAIN)) begin
            rdata_next = {31'h00000000, flag_reg};
         end else if (hit(PADDR, bpc_pkg::OFF_IRQ_TWO)) begin
            rdata_next = {24'h000000, pullup_n_reg, 7'h00};
         end else if (hit(PADDR, bpc_pkg::OFF_ANALOG_SEL)) begin
            rdata_next = {27'h0000000, analog_reg};
         end else if (hit(PADDR, bpc_pkg::OFF_FUNC_CTRL)) begin
            rdata_next = {30'h00000000, func_reg};
         end else begin
            rdata_next = bpc_pkg::RDATA_UNMAPPED;
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         latch_reg    <= bpc_pkg::RST_LATCH;
         dir_reg      <= bpc_pkg::RST_DIRECTION;
         pullup_n_reg <= bpc_pkg::RST_IRQ_TWO[bpc_pkg::BIT_PULLUP_N]; // R6
         flag_reg     <= 1'b0;
         analog_reg   <= bpc_pkg::ANALOG_ALL; // R7
         func_reg     <= 2'h0;
         snap_reg     <= 4'h0;
         init_reg     <= 1'b1;
         rdata_reg    <= 32'h00000000;
      end else begin
         latch_reg    <= latch_next;
         dir_reg      <= dir_next;
         pullup_n_reg <= pullup_n_next;
         flag_reg     <= flag_next;
         analog_reg   <= analog_next;
         func_reg     <= func_next;
         snap_reg     <= snap_next;
         init_reg     <= init_next;
         rdata_reg    <= rdata_next;
      end
   end

   // Pin drive with alternate-function overrides
   always_comb begin
      PIN_OE  = ~dir_reg; // R2
      PIN_OUT = latch_reg; // R2 R17
      if (!CAPCMP2_PIN_SELECT && !dir_reg[3]) begin
         PIN_OUT[3] = CAPCMP_UNIT_TWO_OUT; // R18
      end
      if (LOW_VOLTAGE_PROG_ENABLE) begin
         PIN_OE[5] = 1'b0; // R20
      end
      if (serial_act) begin
         PIN_OE[6]  = 1'b0; // R21
         PIN_OE[7]  = PROG_SERIAL_DATA_OE;
         PIN_OUT[7] = PROG_SERIAL_DATA_OUT;
      end
   end

   always_comb begin
      PIN_PULLUP = {8{!pullup_n_reg}} & dir_reg; // R4 R5
      if (LOW_VOLTAGE_PROG_ENABLE) begin
         PIN_PULLUP[5] = 1'b0;
      end
      if (serial_act) begin
         PIN_PULLUP[7:6] = 2'b00;
      end
   end

   assign ANALOG_SEL          = analog_reg;
   assign CAPCMP_UNIT_TWO_IN  = !CAPCMP2_PIN_SELECT && dir_reg[3] && PIN_IN[3]; // R18
   assign EXT_IRQ             = PIN_IN[2:0]; // R19
   assign PWM_FAULT_INPUT     = func_reg[bpc_pkg::BIT_FAULT_EN] && PIN_IN[0]; // R19
   assign PROG_MODE_ENTRY     = LOW_VOLTAGE_PROG_ENABLE && PIN_IN[5]; // R20
   assign PROG_SERIAL_CLOCK   = serial_act && PIN_IN[6]; // R21
   assign PROG_SERIAL_DATA_IN = serial_act && PIN_IN[7]; // R21
   assign PORT_CHANGE_IRQ     = flag_reg; // R11
   // Combinational so the wake request needs no clock while the core sleeps
   assign WAKE_REQ            = flag_reg || (|mismatch); // R12
endmodule
`default_nettype wire

//--- rtl/bpc_pkg.sv
// Package for the bidirectional change-detect port: register map over APB,
// field positions and reset values.
// Assumes a 32-bit APB bus; each register takes one aligned word.
package bpc_pkg;
   localparam int unsigned PORT_W          = 8;
   localparam int unsigned LOW_PINS        = 5;
   localparam logic [11:0] OFF_PIN_DATA    = 12'h000;
   localparam logic [11:0] OFF_LATCH       = 12'h004;
   localparam logic [11:0] OFF_DIRECTION   = 12'h008;
   localparam logic [11:0] OFF_IRQ_MAIN    = 12'h00c;
   localparam logic [11:0] OFF_IRQ_TWO     = 12'h010;
   localparam logic [11:0] OFF_ANALOG_SEL  = 12'h014;
   localparam logic [11:0] OFF_FUNC_CTRL   = 12'h018;
   localparam int unsigned BIT_CHANGE_FLAG = 0;
   localparam int unsigned BIT_PULLUP_N    = 7;
   localparam int unsigned BIT_FAULT_EN    = 0;
   localparam int unsigned BIT_SERIAL_ACT  = 1;
   localparam logic [7:0]  RST_LATCH       = 8'h00;
   localparam logic [7:0]  RST_DIRECTION   = 8'hff;
   localparam logic [7:0]  RST_IRQ_TWO     = 8'h80;
   localparam logic [4:0]  ANALOG_ALL      = 5'h1f;
   localparam logic [31:0] RDATA_UNMAPPED  = 32'h00000000;
endpackage

//--- sim/bpc_port_properties.sv
// Concurrent checks on the port pins and APB side of bpc_port.
// Assumes zero wait-state APB and the register map of bpc_pkg.
`timescale 1ns/1ps
`default_nettype none
module bpc_chk (
   input wire logic        SYS_CLK, ARST_N, PSEL, PENABLE, PWRITE,
   input wire logic        PORT_CHANGE_IRQ, WAKE_REQ, PROG_MODE_ENTRY,
   input wire logic        LOW_VOLTAGE_PROG_ENABLE, LOW_PINS_ANALOG_DEFAULT,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0]  PSTRB,
   input wire logic [7:0]  PIN_IN, PIN_OUT, PIN_OE, PIN_PULLUP,
   input wire logic [4:0]  ANALOG_SEL,
   input wire logic [2:0]  EXT_IRQ
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!ARST_N);
   wire logic wr = PSEL && PENABLE && PWRITE && PSTRB[0];
   // Pins 5 and 7, and pin 3 in the latch check, are left out where alternate functions may take them over
   a_drive_dir: assert property (wr && PADDR == bpc_pkg::OFF_DIRECTION |=>
      (PIN_OE & 8'h5f) == (~$past(PWDATA[7:0]) & 8'h5f)) else $error("direction not on drivers");
   a_latch_out: assert property (wr && PADDR == bpc_pkg::OFF_LATCH |=>
      (PIN_OUT & 8'h57) == ($past(PWDATA[7:0]) & 8'h57)) else $error("latch not on pins");
   a_pullup_off: assert property ((PIN_PULLUP & PIN_OE) == 8'h00) else $error("pull-up on output");
   a_pullup_ctrl: assert property (wr && PADDR == bpc_pkg::OFF_IRQ_TWO |=>
      (PIN_PULLUP & 8'h5f) == (~PIN_OE & {8{!$past(PWDATA[7])}} & 8'h5f)) else $error("pull-up control");
   a_reset_state: assert property ($rose(ARST_N) |-> PIN_PULLUP == 8'h00 && PIN_OE == 8'h00)
      else $error("reset pin state");
   a_analog_rst: assert property ($rose(ARST_N) |=> ANALOG_SEL == {5{LOW_PINS_ANALOG_DEFAULT}})
      else $error("analog default");
   a_flag_set: assert property (WAKE_REQ && !PORT_CHANGE_IRQ |=> PORT_CHANGE_IRQ)
      else $error("mismatch did not set flag");
   a_flag_clear: assert property ($fell(PORT_CHANGE_IRQ) |->
      $past(wr && PADDR == bpc_pkg::OFF_IRQ_MAIN && !PWDATA[0])) else $error("flag fell unasked");
   a_wake_src: assert property (PORT_CHANGE_IRQ |-> WAKE_REQ) else $error("no wake request");
   a_ext_irq: assert property (EXT_IRQ == PIN_IN[2:0]) else $error("external interrupt inputs");
   a_prog_entry: assert property (PROG_MODE_ENTRY == (LOW_VOLTAGE_PROG_ENABLE && PIN_IN[5]))
      else $error("programming entry input");
   c_flag: cover property ($rose(PORT_CHANGE_IRQ));
   c_pullup: cover property (|PIN_PULLUP);
   c_rd_pins: cover property (PSEL && PENABLE && !PWRITE && PADDR == bpc_pkg::OFF_PIN_DATA);
endmodule
bind bpc_port bpc_chk chk_u (.SYS_CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PORT_CHANGE_IRQ, .WAKE_REQ,
   .PROG_MODE_ENTRY, .LOW_VOLTAGE_PROG_ENABLE, .LOW_PINS_ANALOG_DEFAULT, .PADDR, .PWDATA, .PSTRB,
   .PIN_IN, .PIN_OUT, .PIN_OE, .PIN_PULLUP, .ANALOG_SEL, .EXT_IRQ);
`default_nettype wire

//--- sim/bpc_board.sv
// Board model on the eight port pins: device drive, external drive, pull-up.
// Assumes the device drive wins over any external source.
`timescale 1ns/1ps
`default_nettype none
module bpc_board (
   input  wire logic       clk,
   input  wire logic [7:0] pin_out, pin_oe, pin_pullup, ext_val, ext_en,
   output logic      [7:0] pin_in
);
   logic [7:0] float_reg = 8'h55;
   // A floating pin never holds its last level, so it cannot pass by luck
   always_ff @(posedge clk) float_reg <= ~float_reg;
   always_comb
      for (int i = 0; i < 8; i++)
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pin_pullup[i] ? 1'b1 : float_reg[i];
endmodule
`default_nettype wire

//--- sim/bidir_port_change_interrupt_tb_top.sv
// Self-checking bench for bpc_port: APB tasks, board model, directed tests.
// Assumes PRDATA is valid at the access edge, when PREADY is sampled high.
`timescale 1ns/1ps
`default_nettype none
module bidir_port_change_interrupt_tb_top;
   logic        sys_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        mem_move = 1'b0, strap = 1'b1, cap_sel = 1'b1, pready, pslverr, chg_irq;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [7:0]  pin_in, pin_out, pin_oe, pin_pullup, ext_val = 8'hff, ext_en = 8'hff;
   logic [4:0]  analog_sel;
   int          fail_count = 0, cmp_count = 0;
   bpc_port dut_u (.SYS_CLK(sys_clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'h1), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .MEM_TO_MEM_MOVE(mem_move), .LOW_PINS_ANALOG_DEFAULT(strap), .CAPCMP2_PIN_SELECT(cap_sel),
      .LOW_VOLTAGE_PROG_ENABLE(1'b0), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
      .PIN_PULLUP(pin_pullup), .ANALOG_SEL(analog_sel), .CAPCMP_UNIT_TWO_OUT(1'b0), .CAPCMP_UNIT_TWO_IN(),
      .EXT_IRQ(), .PWM_FAULT_INPUT(), .PROG_MODE_ENTRY(), .PROG_SERIAL_CLOCK(), .PROG_SERIAL_DATA_IN(),
      .PROG_SERIAL_DATA_OUT(1'b0), .PROG_SERIAL_DATA_OE(1'b0), .PORT_CHANGE_IRQ(chg_irq), .WAKE_REQ());
   bpc_board board_u (.clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
      .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
   initial forever #5 sys_clk = ~sys_clk;
   task automatic stop_test();
      $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Entered just after a rising edge; returns just after one
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 20);
      if (n >= 20) begin
         fail_count++;
         stop_test();
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic reset(input logic s);
      strap <= s;
      arst_n <= 1'b0;
      repeat (20) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
   endtask
   initial begin
      reset(1'b1);
      check(pin_pullup, 8'h00);
      check(analog_sel, 5'h1f);
      apb(1'b0, bpc_pkg::OFF_PIN_DATA, 32'h0);
      check(rd, 32'he0);
      apb(1'b0, bpc_pkg::OFF_IRQ_TWO, 32'h0);
      check(rd, 32'h80);
      reset(1'b0);
      check(analog_sel, 5'h00);
      apb(1'b0, bpc_pkg::OFF_PIN_DATA, 32'h0);
      check(rd, 32'hff);
      $display("Test reset defaults done");
      apb(1'b1, bpc_pkg::OFF_LATCH, 32'ha5);
      apb(1'b1, bpc_pkg::OFF_DIRECTION, 32'h0f);
      check(pin_oe, 8'hf0);
      apb(1'b0, bpc_pkg::OFF_PIN_DATA, 32'h0);
      check(rd, 32'haf);
      apb(1'b0, bpc_pkg::OFF_LATCH, 32'h0);
      check(rd, 32'ha5);
      apb(1'b1, bpc_pkg::OFF_PIN_DATA, 32'h3c);
      check(pin_out & 8'hf0, 8'h30);
      $display("Test latch and direction done");
      ext_en <= 8'hf0;
      apb(1'b1, bpc_pkg::OFF_IRQ_TWO, 32'h00);
      check(pin_pullup, 8'h0f);
      apb(1'b0, bpc_pkg::OFF_PIN_DATA, 32'h0);
      check(rd, 32'h3f);
      apb(1'b1, bpc_pkg::OFF_IRQ_TWO, 32'h80);
      check(pin_pullup, 8'h00);
      $display("Test pull-ups done");
      ext_en <= 8'hff;
      ext_val <= 8'h00;
      apb(1'b1, bpc_pkg::OFF_DIRECTION, 32'hff);
      apb(1'b0, bpc_pkg::OFF_PIN_DATA, 32'h0);
      apb(1'b1, bpc_pkg::OFF_IRQ_MAIN, 32'h0);
      check(chg_irq, 1'b0);
      ext_val <= 8'h40;
      repeat (3) @(posedge sys_clk);
      check(chg_irq, 1'b1);
      apb(1'b1, bpc_pkg::OFF_IRQ_MAIN, 32'h0);
      check(chg_irq, 1'b1);
      mem_move <= 1'b1;
      apb(1'b1, bpc_pkg::OFF_PIN_DATA, 32'h0);
      mem_move <= 1'b0;
      apb(1'b1, bpc_pkg::OFF_IRQ_MAIN, 32'h0);
      check(chg_irq, 1'b1);
      apb(1'b0, bpc_pkg::OFF_PIN_DATA, 32'h0);
      apb(1'b1, bpc_pkg::OFF_IRQ_MAIN, 32'h0);
      check(chg_irq, 1'b0);
      apb(1'b1, bpc_pkg::OFF_DIRECTION, 32'h7f);
      apb(1'b1, bpc_pkg::OFF_LATCH, 32'hc0);
      repeat (3) @(posedge sys_clk);
      check(chg_irq, 1'b0);
      $display("Test change detection done");
      stop_test();
   end
endmodule
`default_nettype wire
